// [rtl/quad_sim_sample_sequencer.sv]
`timescale 1ns/10ps
module quad_sim_sample_sequencer
    import sampler_pkg::*;
#(
    parameter int MAX_CONV_CYCLES = CONV_CYCLES_MAX // Trigger to done limit
)(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    reset_n,
    // Converter clock choice
    input  wire logic                    conv_clk,
    input  wire logic                    use_internal_osc,
    // Sample trigger
    input  wire logic                    sample_trigger_n,
    // Host read port
    input  wire logic                    cs_n,
    input  wire logic                    rd_n,
    output logic [RESULT_WIDTH-1:0]      result_bus,
    output logic                         result_bus_oe,
    output logic                         done_n,
    // Analog front end
    input  wire logic                    comp_in,
    output logic [NUM_CHANNELS-1:0]      track_hold,
    output logic [CHAN_IDX_W-1:0]        mux_sel,
    output logic [RESULT_WIDTH-1:0]      dac_code
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    sar_if sar ();                                       // Engine link

    seq_state_type           state_r;                    // Sequencer state
    seq_state_type           state_nxt;
    logic                    trig_s1_r;                  // Sync stage one
    logic                    trig_s2_r;                  // Sync stage two
    logic                    trig_s3_r;                  // Edge history
    logic                    conv_clk_d_r;               // Converter clock history
    logic [6:0]              osc_cnt_r;                  // Internal oscillator divider
    logic                    osc_tick_r;                 // Internal oscillator edge
    logic [1:0]              lead_cnt_r;                 // Lead edges counted
    logic [CHAN_IDX_W-1:0]   chan_r;                     // Channel converting
    logic                    start_r;                    // Engine start pulse
    logic [RESULT_WIDTH-1:0] results_r [NUM_CHANNELS];   // Result registers
    logic [CHAN_IDX_W-1:0]   ptr_r;                      // Read pointer
    logic                    first_read_r;               // Next read is first
    logic                    rd_d_r;                     // Read strobe history
    logic                    done_n_r;                   // Done flag
    logic                    hold_r;                     // Track/holds holding
    logic [RESULT_WIDTH-1:0] bus_r;                      // Read data
    logic                    oe_r;                       // Read output enable

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    wire trig_rise  = trig_s2_r & ~trig_s3_r;
    wire accept     = trig_rise && (state_r == SEQ_IDLE);
    wire ext_tick   = conv_clk & ~conv_clk_d_r;
    wire conv_tick  = use_internal_osc ? osc_tick_r : ext_tick;
    wire lead_end   = (state_r == SEQ_LEAD) && conv_tick && (lead_cnt_r == 2'(START_EDGES - 1));
    wire chan_store = (state_r == SEQ_CONVERT) && sar.done;
    wire last_chan  = (chan_r == CHAN_IDX_W'(NUM_CHANNELS - 1));
    wire seq_finish = chan_store && last_chan;
    wire read_fall  = ~cs_n & ~rd_n & rd_d_r;
    wire read_on    = ~cs_n & ~rd_n;
    wire osc_wrap   = (osc_cnt_r == 7'(OSC_DIV - 1));

    // Engine hookup
    assign sar.start = start_r;
    assign sar.tick  = conv_tick;
    assign sar.comp  = comp_in;

    // Next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SEQ_IDLE:    if (accept) state_nxt = SEQ_LEAD;
            SEQ_LEAD:    if (lead_end) state_nxt = SEQ_CONVERT;
            SEQ_CONVERT: if (seq_finish) state_nxt = SEQ_IDLE;
            default:     state_nxt = SEQ_IDLE;
        endcase
    end

    // Outputs from flip-flops
    assign result_bus    = bus_r;
    assign result_bus_oe = oe_r;
    assign done_n        = done_n_r;
    assign track_hold    = {NUM_CHANNELS{hold_r}};
    assign mux_sel       = chan_r;
    assign dac_code      = sar.dac_code;

    ////////////////////////////////////////////////////////////////////////////
    // Engine instance
    sar_engine u_engine (
        .clock   (clock),
        .reset_n (reset_n),
        .sar     (sar.engine)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Trigger synchroniser, first stage read only by second
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            trig_s1_r <= 1'b1;
            trig_s2_r <= 1'b1;
            trig_s3_r <= 1'b1;
        end else begin
            trig_s1_r <= sample_trigger_n;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // Converter clock edge source
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            conv_clk_d_r <= 1'b0;
            osc_cnt_r    <= 7'h00;
            osc_tick_r   <= 1'b0;
        end else begin
            conv_clk_d_r <= conv_clk;
            osc_cnt_r    <= osc_wrap ? 7'h00 : osc_cnt_r + 7'h01;
            osc_tick_r   <= osc_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r    <= SEQ_IDLE;
            lead_cnt_r <= 2'h0;
            chan_r     <= 2'h0;
            start_r    <= 1'b0;
            hold_r     <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= 1'b0;
            if (accept) begin
                // All channels freeze on one edge
                hold_r     <= 1'b1;
                chan_r     <= 2'h0;
                lead_cnt_r <= 2'h0;
            end
            if ((state_r == SEQ_LEAD) && conv_tick) begin
                lead_cnt_r <= lead_cnt_r + 2'h1;
            end
            if (lead_end) begin
                start_r <= 1'b1;
            end
            if (chan_store && !last_chan) begin
                // Next channel in fixed order
                chan_r  <= chan_r + 2'h1;
                start_r <= 1'b1;
            end
            if (seq_finish) begin
                hold_r <= 1'b0;
            end
        end
    end

    // Result registers, one per channel
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                results_r[i] <= RESULT_RESET;
            end
        end else if (chan_store) begin
            results_r[chan_r] <= sar.result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag, set wins over clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            done_n_r     <= 1'b1;
            first_read_r <= 1'b0;
        end else if (seq_finish) begin
            done_n_r     <= 1'b0;
            first_read_r <= 1'b1;
        end else if (read_fall && first_read_r) begin
            done_n_r     <= 1'b1;
            first_read_r <= 1'b0;
        end
    end

    // Read port, pointer only, no address decode
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_d_r <= 1'b1;
            ptr_r  <= 2'h0;
            bus_r  <= RESULT_RESET;
            oe_r   <= 1'b0;
        end else begin
            rd_d_r <= rd_n;
            oe_r   <= read_on;
            if (trig_rise) begin
                ptr_r <= 2'h0;
            end else if (read_fall) begin
                // Data at pointer, then advance
                bus_r <= results_r[ptr_r];
                ptr_r <= ptr_r + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    logic [7:0]  edge_seen_r;   // Converter edges since accept
    logic [15:0] elapsed_r;     // Cycles since accept
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            edge_seen_r <= 8'h00;
            elapsed_r   <= 16'h0000;
        end else if (accept) begin
            edge_seen_r <= 8'h00;
            elapsed_r   <= 16'h0000;
        end else if (state_r != SEQ_IDLE) begin
            edge_seen_r <= edge_seen_r + 8'(conv_tick);
            elapsed_r   <= elapsed_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_start_seq;
        @(posedge clock) disable iff (!reset_n) accept |=> (state_r == SEQ_LEAD) && (chan_r == 2'h0);
    endproperty
    a_start_seq: assert property (p_start_seq) else $error("Trigger did not start sequence");

    property p_hold_all;
        @(posedge clock) disable iff (!reset_n) accept |=> (track_hold == 4'hf) until seq_finish;
    endproperty
    a_hold_all: assert property (p_hold_all) else $error("Track/holds not all holding");

    property p_chan_order;
        @(posedge clock) disable iff (!reset_n) (chan_store && !last_chan) |=> chan_r == $past(chan_r) + 2'h1;
    endproperty
    a_chan_order: assert property (p_chan_order) else $error("Channel order broken");

    property p_store;
        @(posedge clock) disable iff (!reset_n) chan_store |=> results_r[$past(chan_r)] == $past(sar.result);
    endproperty
    a_store: assert property (p_store) else $error("Result not stored");

    property p_done_after_all;
        @(posedge clock) disable iff (!reset_n) $fell(done_n) |-> $past(chan_r) == 2'h3 && $past(state_r) == SEQ_CONVERT;
    endproperty
    a_done_after_all: assert property (p_done_after_all) else $error("Done before last channel");

    property p_edge_count;
        @(posedge clock) disable iff (!reset_n)
            $fell(done_n) |-> (edge_seen_r >= 8'(SEQ_EDGES - 1)) && (edge_seen_r <= 8'(SEQ_EDGES + 1));
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("Sequence edge count wrong");

    property p_max_time;
        @(posedge clock) disable iff (!reset_n) $fell(done_n) |-> elapsed_r <= 16'(MAX_CONV_CYCLES);
    endproperty
    a_max_time: assert property (p_max_time) else $error("Conversion took too long");

    property p_ptr_step;
        @(posedge clock) disable iff (!reset_n) (read_fall && !trig_rise) |=> ptr_r == $past(ptr_r) + 2'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("Read pointer did not advance");

    property p_first_read;
        @(posedge clock) disable iff (!reset_n)
            (read_fall && first_read_r && !trig_rise) |=> result_bus == $past(results_r[0]);
    endproperty
    a_first_read: assert property (p_first_read) else $error("First read not channel one");

    property p_done_clear;
        @(posedge clock) disable iff (!reset_n) (read_fall && first_read_r && !seq_finish) |=> done_n ##1 done_n;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("Done not cleared by read");

    property p_ptr_reset;
        @(posedge clock) disable iff (!reset_n) trig_rise |=> ptr_r == 2'h0;
    endproperty
    a_ptr_reset: assert property (p_ptr_reset) else $error("Pointer not reset by trigger");

    property p_oe_follow;
        @(posedge clock) disable iff (!reset_n) (cs_n || rd_n) |=> !result_bus_oe;
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("Outputs enabled without read");

    c_full_seq:  cover property (@(posedge clock) disable iff (!reset_n) $fell(done_n));
    c_four_read: cover property (@(posedge clock) disable iff (!reset_n) read_fall && ptr_r == 2'h3);
    c_internal:  cover property (@(posedge clock) disable iff (!reset_n) seq_finish && use_internal_osc);

endmodule : quad_sim_sample_sequencer

// [rtl/sampler_pkg.sv]
package sampler_pkg;

    // Channel and result geometry
    localparam int NUM_CHANNELS = 4;
    localparam int RESULT_WIDTH = 12;
    localparam int CHAN_IDX_W   = 2;

    // Converter clock edges in each phase
    localparam int START_EDGES  = 2;
    localparam int SETTLE_EDGES = 1;
    localparam int RESET_EDGES  = 6;
    localparam int CHAN_EDGES   = SETTLE_EDGES + RESULT_WIDTH + RESET_EDGES;
    localparam int SEQ_EDGES    = START_EDGES + NUM_CHANNELS * CHAN_EDGES;

    // System clock and time limits
    localparam int CLK_PERIOD_NS      = 4;
    localparam int CLK_FREQ_KHZ       = 250000;
    localparam int CONV_TIME_MAX_NS   = 32500;
    localparam int CONV_CYCLES_MAX    = CONV_TIME_MAX_NS / CLK_PERIOD_NS;
    localparam int OSC_FREQ_KHZ       = 2500;
    localparam int OSC_DIV            = CLK_FREQ_KHZ / OSC_FREQ_KHZ;

    // Reset values and start code
    localparam logic [RESULT_WIDTH-1:0] SAR_FIRST_TRIAL = 12'h800;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET    = 12'h000;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_LEAD    = 2'b01,
        SEQ_CONVERT = 2'b10
    } seq_state_type;

    // Offset binary to two's complement
    function automatic logic [RESULT_WIDTH-1:0] to_twos(input logic [RESULT_WIDTH-1:0] code);
        to_twos = {~code[RESULT_WIDTH-1], code[RESULT_WIDTH-2:0]};
    endfunction : to_twos

endpackage : sampler_pkg

// [rtl/sar_engine.sv]
`timescale 1ns/10ps
module sar_engine
    import sampler_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Sequencer side
    sar_if.engine     sar
);

    logic [4:0]              edge_cnt_r;  // Edges into this channel
    logic [4:0]              edge_cnt_nxt;
    logic                    busy_r;      // Channel running
    logic                    done_r;      // Done pulse
    logic [RESULT_WIDTH-1:0] code_r;      // Successive approximation code
    logic [RESULT_WIDTH-1:0] code_nxt;

    // Trial window and current bit mask
    wire                    in_trial  = (edge_cnt_r >= 5'(SETTLE_EDGES)) &&
                                        (edge_cnt_r < 5'(SETTLE_EDGES + RESULT_WIDTH));
    wire [3:0]              trial_pos = 4'(edge_cnt_r - 5'(SETTLE_EDGES));
    wire [RESULT_WIDTH-1:0] mask      = SAR_FIRST_TRIAL >> trial_pos;
    wire                    last_edge = (edge_cnt_r == 5'(CHAN_EDGES - 1));

    // Keep bit when input at or above trial, then try next bit
    assign code_nxt     = in_trial ? ((code_r & ~(sar.comp ? 12'h000 : mask)) | (mask >> 1)) : code_r;
    assign edge_cnt_nxt = edge_cnt_r + 5'h01;

    // Outputs from flip-flops
    assign sar.busy     = busy_r;
    assign sar.done     = done_r;
    assign sar.dac_code = code_r;
    assign sar.result   = to_twos(code_r);

    ////////////////////////////////////////////////////////////////////////////
    // Bit trial sequencing
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            edge_cnt_r <= 5'h00;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            code_r     <= SAR_FIRST_TRIAL;
        end else begin
            done_r <= 1'b0;
            if (sar.start) begin
                // Fresh channel, MSB trial first
                edge_cnt_r <= 5'h00;
                busy_r     <= 1'b1;
                code_r     <= SAR_FIRST_TRIAL;
            end else if (busy_r && sar.tick) begin
                // One converter edge
                code_r     <= code_nxt;
                edge_cnt_r <= edge_cnt_nxt;
                if (last_edge) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

endmodule : sar_engine

// [rtl/sar_if.sv]
`timescale 1ns/10ps
interface sar_if;
    import sampler_pkg::*;
    logic                    start;    // Begin one channel
    logic                    tick;     // Converter clock edge
    logic                    comp;     // Comparator decision
    logic                    busy;     // Channel in progress
    logic                    done;     // Result ready pulse
    logic [RESULT_WIDTH-1:0] dac_code; // Trial code to DAC
    logic [RESULT_WIDTH-1:0] result;   // Two's complement result

    modport engine (input start, tick, comp, output busy, done, dac_code, result);
    modport seq    (output start, tick, comp, input busy, done, dac_code, result);
endinterface : sar_if

// [verification/analog_front_model.sv]
`timescale 1ns/10ps
module analog_front_model
    import sampler_pkg::*;
(
    // Clock
    input  wire logic                                 clock,
    // Levels on the four inputs, offset binary
    input  wire logic [NUM_CHANNELS*RESULT_WIDTH-1:0] level_in,
    // Converter side
    input  wire logic [NUM_CHANNELS-1:0]              track_hold,
    input  wire logic [CHAN_IDX_W-1:0]                mux_sel,
    input  wire logic [RESULT_WIDTH-1:0]              dac_code,
    output logic                                      comp_in
);
    ////////////////////////////////////////////////////////////////////////
    logic [RESULT_WIDTH-1:0] held [NUM_CHANNELS]; // Hold capacitor levels

    // Each channel follows its input while tracking, frozen while holding
    always @(posedge clock) begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (track_hold[i] !== 1'b1) begin
                held[i] <= level_in[i*RESULT_WIDTH +: RESULT_WIDTH];
            end
        end
    end

    // Comparator: high when held level at or above the trial code
    assign comp_in = (held[mux_sel] >= dac_code);
endmodule : analog_front_model

// [verification/testbench.sv]
`timescale 1ns/10ps
module testbench;
    import sampler_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic                                 clock, reset_n, use_internal_osc;
    logic                                 conv_clk = 1'b0; // Converter clock, one driver
    logic                                 sample_trigger_n, cs_n, rd_n, comp_in;
    logic [RESULT_WIDTH-1:0]              result_bus, dac_code;
    logic                                 result_bus_oe, done_n;
    logic [NUM_CHANNELS-1:0]              track_hold;
    logic [CHAN_IDX_W-1:0]                mux_sel;
    logic [NUM_CHANNELS*RESULT_WIDTH-1:0] level_in;   // Analog levels
    int                                   error_cnt, num_checks, seed, rd_ptr, conv_div;
    logic [RESULT_WIDTH-1:0]              exp_res [NUM_CHANNELS]; // Model result registers
    int                                   vals [NUM_CHANNELS];    // Signed input steps

    quad_sim_sample_sequencer #(.MAX_CONV_CYCLES(CONV_CYCLES_MAX)) i_quad_sim_sample_sequencer (
        .clock(clock), .reset_n(reset_n), .conv_clk(conv_clk), .use_internal_osc(use_internal_osc),
        .sample_trigger_n(sample_trigger_n), .cs_n(cs_n), .rd_n(rd_n), .result_bus(result_bus),
        .result_bus_oe(result_bus_oe), .done_n(done_n), .comp_in(comp_in),
        .track_hold(track_hold), .mux_sel(mux_sel), .dac_code(dac_code));

    analog_front_model i_analog_front_model (
        .clock(clock), .level_in(level_in), .track_hold(track_hold),
        .mux_sel(mux_sel), .dac_code(dac_code), .comp_in(comp_in));

    ////////////////////////////////////////////////////////////////////////
    // System clock
    initial clock = 1'b0;
    always #(CLK_PERIOD_NS/2) clock = ~clock;

    // External converter clock, 2.5 MHz
    always @(posedge clock) begin
        conv_div <= (conv_div == 49) ? 0 : conv_div + 1;
        if (conv_div == 49) begin
            conv_clk <= ~conv_clk;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare a data word
    task automatic check_word(input logic [RESULT_WIDTH-1:0] act, input logic [RESULT_WIDTH-1:0] exp,
                              input string what);
        num_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, act, exp);
        end
    endtask : check_word

    // Compare a single flag
    task automatic check_bit(input logic act, input logic exp, input string what);
        num_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, act, exp);
        end
    endtask : check_bit

    // Trigger one sequence and wait for completion
    task automatic convert();
        int     cyc;
        longint t0;
        for (int k = 0; k < NUM_CHANNELS; k++) begin
            level_in[k*RESULT_WIDTH +: RESULT_WIDTH] <= 12'(vals[k] + 2048);
            exp_res[k] = 12'(vals[k]);
        end
        @(posedge clock);
        sample_trigger_n <= 1'b0;
        repeat (3) @(posedge clock);
        sample_trigger_n <= 1'b1;
        t0 = $time;
        rd_ptr = 0;
        repeat (20) @(posedge clock);
        #1 check_word(12'(track_hold), 12'h00f, "all channels held");
        check_word(12'(mux_sel), 12'h000, "channel 1 first");
        // Inputs move after the hold; results must not follow
        @(posedge clock);
        level_in <= ~level_in;
        cyc = 0;
        while (done_n !== 1'b0 && cyc < 9000) begin
            @(posedge clock);
            #1 cyc++;
        end
        cyc = int'(($time - t0) / CLK_PERIOD_NS);
        check_bit(done_n, 1'b0, "done after sequence");
        check_bit(cyc <= CONV_CYCLES_MAX, 1'b1, "trigger to done limit");
        check_bit(cyc >= (SEQ_EDGES - 1) * OSC_DIV, 1'b1, "sequence length");
        check_word(12'(track_hold), 12'h000, "back to tracking");
        check_word(12'(mux_sel), 12'(NUM_CHANNELS - 1), "channel 4 last");
    endtask : convert

    // One host read at the single result address
    task automatic read_word();
        @(posedge clock);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check_word(result_bus, exp_res[rd_ptr], "read data");
        check_bit(result_bus_oe, 1'b1, "drive enable on read");
        check_bit(done_n, 1'b1, "done cleared by read");
        rd_ptr = (rd_ptr + 1) % NUM_CHANNELS;
        @(posedge clock);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check_bit(result_bus_oe, 1'b0, "drive released");
    endtask : read_word

    // Strobe without select: no drive, pointer kept
    task automatic stray_strobe();
        @(posedge clock);
        rd_n <= 1'b0;
        repeat (2) @(posedge clock);
        #1 check_bit(result_bus_oe, 1'b0, "no drive unselected");
        check_bit(done_n, 1'b0, "done kept without select");
        @(posedge clock);
        rd_n <= 1'b1;
    endtask : stray_strobe

    // Counts and verdict
    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Watchdog against a hung sequence
    initial begin
        repeat (5 * CONV_CYCLES_MAX) @(posedge clock);
        error_cnt++;
        complete_run();
    end

    // Main sequence
    initial begin
        seed = 13633;
        error_cnt = 0;
        num_checks = 0;
        use_internal_osc = 1'b0;
        sample_trigger_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        level_in = '0;
        reset_n = 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        #1 check_bit(done_n, 1'b1, "reset done flag");
        check_bit(result_bus_oe, 1'b0, "reset drive enable");
        check_word(dac_code, SAR_FIRST_TRIAL, "reset trial code");
        check_word(12'(track_hold), 12'h000, "reset tracking");
        check_word(12'(mux_sel), 12'h000, "reset channel select");
        // Code boundaries, external clock, five reads wrap
        vals = '{-1, 0, 2047, -2048};
        convert();
        for (int r = 0; r < 5; r++) begin
            read_word();
        end
        // Near-boundary codes on the internal oscillator, partial read
        vals = '{-2047, 2046, 1, -2};
        use_internal_osc <= 1'b1;
        convert();
        stray_strobe();
        read_word();
        read_word();
        // Random codes; new trigger restarts pointer at channel 1
        for (int k = 0; k < NUM_CHANNELS; k++) begin
            vals[k] = $random(seed) % 2048;
        end
        convert();
        for (int r = 0; r < NUM_CHANNELS; r++) begin
            read_word();
        end
        complete_run();
    end
endmodule : testbench
